// ### inc/enc_obj_pkg.sv
// Object dictionary constants for the encoder parameter object bank.
// Assumes an SDO engine outside that presents index, subindex and data.
package enc_obj_pkg;
    localparam logic [15:0] IDX_PRESET      = 16'h2103;
    localparam logic [15:0] IDX_LIM_MIN     = 16'h2104;
    localparam logic [15:0] IDX_LIM_MAX     = 16'h2105;
    localparam logic [15:0] IDX_SCRATCH     = 16'h2160;
    localparam logic [15:0] IDX_CYCLE       = 16'h2200;
    localparam logic [15:0] IDX_SAVE        = 16'h2300;
    localparam logic [15:0] IDX_NODE        = 16'h3000;
    localparam logic [15:0] IDX_RATE        = 16'h3001;
    localparam logic [15:0] IDX_TERM        = 16'h3002;
    localparam logic [15:0] IDX_SPEED       = 16'h3010;
    localparam logic [7:0]  SCRATCH_COUNT   = 8'h04;
    localparam logic [7:0]  SPEED_COUNT     = 8'h02;
    localparam logic [31:0] SAVE_KEY        = 32'h55aaaa55;
    localparam logic [7:0]  NODE_RST        = 8'h1f;
    localparam logic [7:0]  RATE_MAX        = 8'h07;
    localparam logic [7:0]  RATE_RST        = 8'h03;
    localparam int          POS_W           = 30;
    localparam int          BIT_LIM_MIN     = 30;
    localparam int          BIT_LIM_MAX     = 31;
    localparam int          OPB_LIM_MIN     = 1;
    localparam int          OPB_LIM_MAX     = 2;
    localparam logic [31:0] ABORT_OK        = 32'h00000000;
    localparam logic [31:0] ABORT_RANGE     = 32'h06090030;
    localparam logic [31:0] ABORT_NOOBJ     = 32'h06020000;
    localparam logic [31:0] ABORT_RO        = 32'h06010002;
    localparam logic [31:0] ABORT_WO        = 32'h06010001;
    typedef enum logic [2:0] {
        RATE_20K, RATE_50K, RATE_100K, RATE_125K,
        RATE_250K, RATE_500K, RATE_800K, RATE_1000K
    } bit_rate_t;
endpackage

// ### inc/nvm_if.sv
// Save request handshake between the object bank and its save sequencer.
// Assumes one clock shared by both ends.
`timescale 1ns/100ps
interface nvm_if;
    logic start;
    logic busy;
    logic done;
    modport bank (output start, input busy, input done);
    modport seq  (input start, output busy, output done);
endinterface

// ### hw/save_seq.sv
// Save-then-reset sequencer: hands parameters to nonvolatile storage,
// then pulses a device reset request. Assumes the store acks with done.
`timescale 1ns/100ps
module save_seq (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    nvm_if.seq        ctl,
    input  wire logic store_done_i,
    output logic      store_req_o,
    output logic      reboot_o
);
    typedef enum logic [1:0] {S_IDLE, S_STORE, S_BOOT} seq_state_t;
    seq_state_t st_r;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r        <= S_IDLE;
            store_req_o <= 1'b0;
            reboot_o    <= 1'b0;
        end else begin
            case (st_r)
                S_IDLE: begin
                    reboot_o <= 1'b0;
                    if (ctl.start) begin
                        st_r        <= S_STORE;
                        store_req_o <= 1'b1;
                    end
                end
                S_STORE: begin
                    if (store_done_i) begin
                        store_req_o <= 1'b0;
                        st_r        <= S_BOOT;
                    end
                end
                S_BOOT: begin
                    reboot_o <= 1'b1;
                    st_r     <= S_IDLE;
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    assign ctl.busy = (st_r != S_IDLE);
    assign ctl.done = (st_r == S_BOOT);
endmodule

// ### hw/enc_param_bank.sv
// Encoder parameter object bank reached by SDO requests, plus process value.
// Assumes the SDO engine gives one-cycle requests and waits for ack.
//
// Contract
// - Preset write shifts output so the current shaft reports the preset.
// - Preset above total resolution is aborted out of range, old kept.
// - Limit threshold above total resolution is aborted out of range.
// - Process value: bits 31..30 limit status, bits 29..0 position.
// - Position at or below min threshold sets bit 30 next message.
// - Position at or above max threshold sets bit 31 next message.
// - Four volatile read/write scratch words and read-only count 4.
// - Read-only 16-bit cycle time equals the linked event timer value.
// - Writing key 55AAAA55h stores all parameters then resets.
// - Node address is 00h during reset, then the stored node byte plus one.
// - Bit-rate code 00h..07h selects 20 to 1000 kbit/s.
// - One-bit termination flag drives the relay, off by default.
// - Speed enable and mode bytes reset zero; read-only count 2.
// - Min bit uses operating bit 1, max bit uses operating bit 2.
`timescale 1ns/100ps
module enc_param_bank
    import enc_obj_pkg::*;
(
    input  wire logic                      clk_i,
    input  wire logic                      nrst_i,
    input  wire logic                      req_i,
    input  wire logic                      wr_i,
    input  wire logic [15:0]               index_i,
    input  wire logic [7:0]                sub_i,
    input  wire logic [31:0]               wdata_i,
    output logic                           ack_o,
    output logic [31:0]                    rdata_o,
    output logic [31:0]                    abort_o,
    input  wire logic [31:0]               total_res_i,
    input  wire logic [7:0]                op_param_i,
    input  wire logic [15:0]               event_timer_i,
    input  wire logic [POS_W-1:0]          raw_pos_i,
    input  wire logic                      msg_strobe_i,
    input  wire logic                      store_done_i,
    output logic [31:0]                    process_value_o,
    output logic [31:0]                    preset_o,
    output logic [7:0]                     node_addr_o,
    output enc_obj_pkg::bit_rate_t         bit_rate_o,
    output logic                           term_relay_o,
    output logic [7:0]                     speed_en_o,
    output logic [7:0]                     speed_mode_o,
    output logic                           store_req_o,
    output logic                           reboot_o
);
    import enc_obj_pkg::*;

    logic [31:0]      preset_r;
    logic [31:0]      lim_min_r;
    logic [31:0]      lim_max_r;
    logic [31:0]      scratch_r [4];
    logic [POS_W-1:0] offset_r;
    logic [7:0]       node_r;
    logic [7:0]       rate_r;
    logic             term_r;
    logic [7:0]       spd_en_r;
    logic [7:0]       spd_mode_r;
    logic [POS_W-1:0] pos_now;
    logic             hit_min;
    logic             hit_max;
    logic             wr_req;
    logic [31:0]      err_nxt;
    logic [31:0]      rd_nxt;

    nvm_if nvm ();

    save_seq u_seq (
        .clk_i        (clk_i),
        .nrst_i       (nrst_i),
        .ctl          (nvm.bank),
        .store_done_i (store_done_i),
        .store_req_o  (store_req_o),
        .reboot_o     (reboot_o)
    );

    // Range check against the configured total resolution
    function automatic logic over_res(input logic [31:0] v,
                                      input logic [31:0] lim);
        return v > lim;
    endfunction

    function automatic logic is_obj(input logic [15:0] idx,
                                    input logic [15:0] want);
        return idx == want;
    endfunction

    assign wr_req = req_i && wr_i;
    assign pos_now = raw_pos_i + offset_r;
    assign hit_min = op_param_i[OPB_LIM_MIN]
                     && ({2'b00, pos_now} <= lim_min_r);
    assign hit_max = op_param_i[OPB_LIM_MAX]
                     && ({2'b00, pos_now} >= lim_max_r);

    // Write validation and abort code
    always_comb begin
        err_nxt = ABORT_OK;
        if (is_obj(index_i, IDX_PRESET) || is_obj(index_i, IDX_LIM_MIN)
            || is_obj(index_i, IDX_LIM_MAX)) begin
            if (over_res(wdata_i, total_res_i))
                err_nxt = ABORT_RANGE;
        end else if (is_obj(index_i, IDX_SCRATCH)) begin
            if (sub_i == 8'h00)
                err_nxt = ABORT_RO;
            else if (sub_i > SCRATCH_COUNT)
                err_nxt = ABORT_NOOBJ;
        end else if (is_obj(index_i, IDX_CYCLE)) begin
            err_nxt = ABORT_RO;
        end else if (is_obj(index_i, IDX_RATE)) begin
            if (wdata_i[7:0] > RATE_MAX)
                err_nxt = ABORT_RANGE;
        end else if (is_obj(index_i, IDX_SPEED)) begin
            if (sub_i == 8'h00)
                err_nxt = ABORT_RO;
            else if (sub_i > SPEED_COUNT)
                err_nxt = ABORT_NOOBJ;
        end else if (!(is_obj(index_i, IDX_SAVE) || is_obj(index_i, IDX_NODE)
                       || is_obj(index_i, IDX_TERM))) begin
            err_nxt = ABORT_NOOBJ;
        end
    end

    // Read data mux
    always_comb begin
        rd_nxt = 32'h00000000;
        case (index_i)
            IDX_PRESET:  rd_nxt = preset_r;
            IDX_LIM_MIN: rd_nxt = lim_min_r;
            IDX_LIM_MAX: rd_nxt = lim_max_r;
            IDX_SCRATCH: begin
                if (sub_i == 8'h00)
                    rd_nxt = {24'h000000, SCRATCH_COUNT};
                else if (sub_i <= SCRATCH_COUNT)
                    rd_nxt = scratch_r[sub_i[1:0] - 2'd1];
            end
            IDX_CYCLE:   rd_nxt = {16'h0000, event_timer_i};
            IDX_NODE:    rd_nxt = {24'h000000, node_r};
            IDX_RATE:    rd_nxt = {24'h000000, rate_r};
            IDX_TERM:    rd_nxt = {31'h0, term_r};
            IDX_SPEED: begin
                case (sub_i)
                    8'h00:   rd_nxt = {24'h000000, SPEED_COUNT};
                    8'h01:   rd_nxt = {24'h000000, spd_en_r};
                    8'h02:   rd_nxt = {24'h000000, spd_mode_r};
                    default: rd_nxt = 32'h00000000;
                endcase
            end
            default:     rd_nxt = 32'h00000000;
        endcase
    end

    // Read error: save key is write-only, unknown objects abort
    function automatic logic [31:0] rd_err(input logic [15:0] idx,
                                           input logic [7:0] sub);
        case (idx)
            IDX_SAVE:    return ABORT_WO;
            IDX_SCRATCH: return (sub > SCRATCH_COUNT) ? ABORT_NOOBJ : ABORT_OK;
            IDX_SPEED:   return (sub > SPEED_COUNT) ? ABORT_NOOBJ : ABORT_OK;
            IDX_PRESET, IDX_LIM_MIN, IDX_LIM_MAX, IDX_CYCLE,
            IDX_NODE, IDX_RATE, IDX_TERM: return ABORT_OK;
            default:     return ABORT_NOOBJ;
        endcase
    endfunction

    // Answer: one cycle after the request
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_o   <= 1'b0;
            rdata_o <= 32'h00000000;
            abort_o <= ABORT_OK;
        end else begin
            ack_o <= req_i;
            if (req_i) begin
                rdata_o <= wr_i ? 32'h00000000 : rd_nxt;
                abort_o <= wr_i ? err_nxt : rd_err(index_i, sub_i);
            end
        end
    end

    // Preset and position offset
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            preset_r <= 32'h00000000;
            offset_r <= '0;
        end else if (wr_req && is_obj(index_i, IDX_PRESET)
                     && err_nxt == ABORT_OK) begin
            preset_r <= wdata_i;
            offset_r <= wdata_i[POS_W-1:0] - raw_pos_i;
        end
    end

    // Limit thresholds
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lim_min_r <= 32'h00000000;
            lim_max_r <= 32'h00000000;
        end else if (wr_req && err_nxt == ABORT_OK) begin
            if (is_obj(index_i, IDX_LIM_MIN))
                lim_min_r <= wdata_i;
            if (is_obj(index_i, IDX_LIM_MAX))
                lim_max_r <= wdata_i;
        end
    end

    // Volatile scratch words
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < 4; i++)
                scratch_r[i] <= 32'h00000000;
        end else if (wr_req && is_obj(index_i, IDX_SCRATCH)
                     && err_nxt == ABORT_OK) begin
            scratch_r[sub_i[1:0] - 2'd1] <= wdata_i;
        end
    end

    // Communication settings
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            node_r <= NODE_RST;
            rate_r <= RATE_RST;
            term_r <= 1'b0;
        end else if (wr_req && err_nxt == ABORT_OK) begin
            if (is_obj(index_i, IDX_NODE))
                node_r <= wdata_i[7:0];
            if (is_obj(index_i, IDX_RATE))
                rate_r <= wdata_i[7:0];
            if (is_obj(index_i, IDX_TERM))
                term_r <= wdata_i[0];
        end
    end

    // Speed control bytes
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            spd_en_r   <= 8'h00;
            spd_mode_r <= 8'h00;
        end else if (wr_req && is_obj(index_i, IDX_SPEED)
                     && err_nxt == ABORT_OK) begin
            if (sub_i == 8'h01)
                spd_en_r <= wdata_i[7:0];
            if (sub_i == 8'h02)
                spd_mode_r <= wdata_i[7:0];
        end
    end

    // Save key: only the exact key starts the store-and-reset
    assign nvm.start = wr_req && is_obj(index_i, IDX_SAVE)
                       && wdata_i == SAVE_KEY && !nvm.busy;

    // Process value, refreshed per transmitted message
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            process_value_o <= 32'h00000000;
        end else if (msg_strobe_i) begin
            process_value_o[POS_W-1:0]  <= pos_now;
            process_value_o[BIT_LIM_MIN] <= hit_min;
            process_value_o[BIT_LIM_MAX] <= hit_max;
        end
    end

    // Registered setting outputs
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            preset_o     <= 32'h00000000;
            node_addr_o  <= 8'h00;
            bit_rate_o   <= RATE_125K;
            term_relay_o <= 1'b0;
            speed_en_o   <= 8'h00;
            speed_mode_o <= 8'h00;
        end else begin
            preset_o     <= preset_r;
            node_addr_o  <= node_r + 8'h01;
            bit_rate_o   <= bit_rate_t'(rate_r[2:0]);
            term_relay_o <= term_r;
            speed_en_o   <= spd_en_r;
            speed_mode_o <= spd_mode_r;
        end
    end
endmodule

// ### bench/nvm_store_model.sv
// Behavioural nonvolatile store that acknowledges save requests.
// Assumes store_req_i stays high until the done pulse has been seen.
`timescale 1ns/100ps
module nvm_store_model (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic store_req_i,
    input  wire logic slow_i,
    output logic      store_done_o
);
    int cnt;

    // One-cycle done after a short or a long write time
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt          <= 0;
            store_done_o <= 1'b0;
        end else begin
            store_done_o <= 1'b0;
            if (store_req_i && !store_done_o) begin
                if (cnt == (slow_i ? 12 : 1)) begin
                    store_done_o <= 1'b1;
                    cnt          <= 0;
                end else begin
                    cnt <= cnt + 1;
                end
            end
        end
    end
endmodule

// ### bench/enc_param_bank_monitor.sv
// Port-level assertions for the encoder parameter bank.
// Assumes one clock domain and the one-cycle SDO answer timing.
`timescale 1ns/100ps
module enc_param_bank_monitor (
    input wire logic                  clk_i,
    input wire logic                  nrst_i,
    input wire logic                  req_i,
    input wire logic                  wr_i,
    input wire logic [15:0]           index_i,
    input wire logic [7:0]            sub_i,
    input wire logic [31:0]           wdata_i,
    input wire logic [31:0]           abort_o,
    input wire logic [31:0]           total_res_i,
    input wire logic [7:0]            op_param_i,
    input wire logic                  msg_strobe_i,
    input wire logic [31:0]           process_value_o,
    input wire logic [7:0]            node_addr_o,
    input wire enc_obj_pkg::bit_rate_t bit_rate_o,
    input wire logic                  term_relay_o,
    input wire logic                  store_req_o,
    input wire logic                  reboot_o
);
    import enc_obj_pkg::*;
    logic wr_acc;
    assign wr_acc = req_i && wr_i && sub_i == 8'h00;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_key_wr;
        wr_acc && index_i == IDX_SAVE && wdata_i == SAVE_KEY
            && !store_req_o && !reboot_o && !$past(store_req_o);
    endsequence
    sequence s_store_end;
        store_req_o ##1 !store_req_o;
    endsequence

    property p_preset_range;
        wr_acc && index_i == IDX_PRESET && wdata_i > total_res_i
            |=> abort_o == ABORT_RANGE;
    endproperty
    a_preset_range: assert property (p_preset_range)
        else $error("oversized preset not refused");
    property p_lim_range;
        wr_acc && (index_i == IDX_LIM_MIN || index_i == IDX_LIM_MAX)
            && wdata_i > total_res_i |=> abort_o == ABORT_RANGE;
    endproperty
    a_lim_range: assert property (p_lim_range)
        else $error("oversized threshold not refused");
    property p_rate_bad;
        wr_acc && index_i == IDX_RATE && wdata_i[7:0] > RATE_MAX
            |=> abort_o == ABORT_RANGE ##1 $stable(bit_rate_o);
    endproperty
    a_rate_bad: assert property (p_rate_bad)
        else $error("bad rate code accepted");
    property p_rate_set;
        wr_acc && index_i == IDX_RATE && wdata_i[7:0] <= RATE_MAX
            |=> ##1 bit_rate_o == $past(wdata_i[2:0], 2);
    endproperty
    a_rate_set: assert property (p_rate_set)
        else $error("rate output differs from code");
    property p_node;
        wr_acc && index_i == IDX_NODE
            |=> ##1 node_addr_o == $past(wdata_i[7:0], 2) + 8'h01;
    endproperty
    a_node: assert property (p_node)
        else $error("node address not byte plus one");
    property p_term;
        wr_acc && index_i == IDX_TERM
            |=> ##1 term_relay_o == $past(wdata_i[0], 2);
    endproperty
    a_term: assert property (p_term)
        else $error("relay does not follow flag");
    property p_lim_off;
        msg_strobe_i |=> ($past(op_param_i[1]) || !process_value_o[30])
            && ($past(op_param_i[2]) || !process_value_o[31]);
    endproperty
    a_lim_off: assert property (p_lim_off)
        else $error("disabled limit bit set");
    property p_save_start;
        s_key_wr |-> ##[1:2] store_req_o;
    endproperty
    a_save_start: assert property (p_save_start)
        else $error("key write did not start storing");
    property p_reboot;
        s_store_end |=> reboot_o ##1 !reboot_o;
    endproperty
    a_reboot: assert property (p_reboot)
        else $error("no reset pulse after storing");
    property p_nokey;
        wr_acc && index_i == IDX_SAVE && wdata_i != SAVE_KEY
            && !store_req_o && !$past(req_i) |=> !store_req_o [*3];
    endproperty
    a_nokey: assert property (p_nokey)
        else $error("wrong key started storing");
endmodule

bind enc_param_bank enc_param_bank_monitor enc_param_bank_monitor_inst (
    .clk_i(clk_i), .nrst_i(nrst_i), .req_i(req_i), .wr_i(wr_i),
    .index_i(index_i), .sub_i(sub_i), .wdata_i(wdata_i),
    .abort_o(abort_o), .total_res_i(total_res_i), .op_param_i(op_param_i),
    .msg_strobe_i(msg_strobe_i), .process_value_o(process_value_o),
    .node_addr_o(node_addr_o), .bit_rate_o(bit_rate_o),
    .term_relay_o(term_relay_o), .store_req_o(store_req_o),
    .reboot_o(reboot_o)
);

// ### bench/testbench.sv
// Self-checking bench for the encoder parameter bank via SDO accesses.
// Assumes the store model answers save requests.
`timescale 1ns/100ps
module testbench;
    import enc_obj_pkg::*;
    logic        clk_i, nrst_i, req_i, wr_i, msg_strobe_i, store_done_i;
    logic        ack_o, term_relay_o, store_req_o, reboot_o, slow;
    logic [15:0] index_i, event_timer_i;
    logic [7:0]  sub_i, op_param_i, node_addr_o, speed_en_o, speed_mode_o;
    logic [31:0] wdata_i, rdata_o, abort_o, total_res_i;
    logic [31:0] process_value_o, preset_o;
    logic [POS_W-1:0] raw_pos_i;
    bit_rate_t   bit_rate_o;
    int          err_count, compares, i, k;

    enc_param_bank enc_param_bank_inst (.clk_i(clk_i), .nrst_i(nrst_i),
        .req_i(req_i), .wr_i(wr_i), .index_i(index_i), .sub_i(sub_i),
        .wdata_i(wdata_i), .ack_o(ack_o), .rdata_o(rdata_o),
        .abort_o(abort_o), .total_res_i(total_res_i),
        .op_param_i(op_param_i), .event_timer_i(event_timer_i),
        .raw_pos_i(raw_pos_i), .msg_strobe_i(msg_strobe_i),
        .store_done_i(store_done_i), .process_value_o(process_value_o),
        .preset_o(preset_o), .node_addr_o(node_addr_o),
        .bit_rate_o(bit_rate_o), .term_relay_o(term_relay_o),
        .speed_en_o(speed_en_o), .speed_mode_o(speed_mode_o),
        .store_req_o(store_req_o), .reboot_o(reboot_o));
    nvm_store_model nvm_store_model_inst (.clk_i(clk_i), .nrst_i(nrst_i),
        .store_req_i(store_req_o), .slow_i(slow),
        .store_done_o(store_done_i));

    task automatic chk(input string nm, input logic [31:0] exp, got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic settle;
        @(posedge clk_i);
        #1;
    endtask
    task automatic sdo(input logic w, input logic [15:0] idx,
                       input logic [7:0] sb, input logic [31:0] d, ab);
        @(posedge clk_i);
        req_i   <= 1'b1;
        wr_i    <= w;
        index_i <= idx;
        sub_i   <= sb;
        wdata_i <= d;
        @(posedge clk_i);
        req_i <= 1'b0;
        #1;
        chk("ack", 32'h1, {31'h0, ack_o});
        chk("abort", ab, abort_o);
    endtask
    task automatic rd(input logic [15:0] idx, input logic [7:0] sb,
                      input logic [31:0] exp);
        sdo(1'b0, idx, sb, 32'h0, ABORT_OK);
        chk("rdata", exp, rdata_o);
    endtask
    task automatic pv(input logic [POS_W-1:0] raw, input logic [7:0] op,
                      input logic [31:0] exp);
        @(posedge clk_i);
        raw_pos_i    <= raw;
        op_param_i   <= op;
        msg_strobe_i <= 1'b1;
        @(posedge clk_i);
        msg_strobe_i <= 1'b0;
        #1;
        chk("process", exp, process_value_o);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        repeat (6000) @(posedge clk_i);
        err_count++;
        conclude();
    end

    initial begin
        {nrst_i, req_i, wr_i, msg_strobe_i, slow} = 5'h0;
        {index_i, sub_i, wdata_i, op_param_i} = '0;
        {err_count, compares} = '0;
        total_res_i   = 32'h0000ffff;
        event_timer_i = 16'h01f4;
        raw_pos_i     = 30'h3e8;
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd(IDX_SCRATCH, 8'h00, 32'h4);
        rd(IDX_CYCLE, 8'h00, 32'h01f4);
        sdo(1'b1, IDX_CYCLE, 8'h00, 32'h5, ABORT_RO);
        rd(IDX_NODE, 8'h00, 32'h1f);
        chk("node_addr", 32'h20, {24'h0, node_addr_o});
        rd(IDX_TERM, 8'h00, 32'h0);
        rd(IDX_SPEED, 8'h00, 32'h2);
        rd(IDX_SPEED, 8'h01, 32'h0);
        rd(IDX_SPEED, 8'h02, 32'h0);
        sdo(1'b0, 16'h2400, 8'h00, 32'h0, ABORT_NOOBJ);
        sdo(1'b0, IDX_SAVE, 8'h00, 32'h0, ABORT_WO);
        for (i = 1; i < 5; i++)
            sdo(1'b1, IDX_SCRATCH, 8'(i), 32'ha5a50000 + i, ABORT_OK);
        for (i = 1; i < 5; i++)
            rd(IDX_SCRATCH, 8'(i), 32'ha5a50000 + i);
        sdo(1'b1, IDX_PRESET, 8'h00, 32'h1f4, ABORT_OK);
        pv(30'h3f2, 8'h00, 32'h000001fe);
        sdo(1'b1, IDX_PRESET, 8'h00, 32'h00010000, ABORT_RANGE);
        rd(IDX_PRESET, 8'h00, 32'h1f4);
        chk("preset", 32'h1f4, preset_o);
        sdo(1'b1, IDX_LIM_MIN, 8'h00, 32'h1f9, ABORT_OK);
        sdo(1'b1, IDX_LIM_MAX, 8'h00, 32'h208, ABORT_OK);
        sdo(1'b1, IDX_LIM_MIN, 8'h00, 32'h00010000, ABORT_RANGE);
        sdo(1'b1, IDX_LIM_MAX, 8'h00, 32'h00010000, ABORT_RANGE);
        rd(IDX_LIM_MIN, 8'h00, 32'h1f9);
        pv(30'h3ed, 8'h06, 32'h400001f9);
        pv(30'h3f2, 8'h06, 32'h000001fe);
        pv(30'h3ec, 8'h00, 32'h000001f8);
        pv(30'h3fc, 8'h06, 32'h80000208);
        pv(30'h3fc, 8'h02, 32'h00000208);
        for (i = 0; i < 8; i++) begin
            sdo(1'b1, IDX_RATE, 8'h00, i, ABORT_OK);
            settle();
            chk("bit_rate", i, bit_rate_o);
        end
        sdo(1'b1, IDX_RATE, 8'h00, 32'h8, ABORT_RANGE);
        rd(IDX_RATE, 8'h00, 32'h7);
        chk("bit_rate", 32'h7, bit_rate_o);
        for (i = 0; i < 6; i += 5) begin
            sdo(1'b1, IDX_NODE, 8'h00, i, ABORT_OK);
            settle();
            chk("node_addr", i + 1, node_addr_o);
        end
        sdo(1'b1, IDX_TERM, 8'h00, 32'h1, ABORT_OK);
        settle();
        chk("relay", 32'h1, term_relay_o);
        sdo(1'b1, IDX_SPEED, 8'h01, 32'h1, ABORT_OK);
        sdo(1'b1, IDX_SPEED, 8'h02, 32'h2, ABORT_OK);
        settle();
        chk("speed_en", 32'h1, speed_en_o);
        chk("speed_mode", 32'h2, speed_mode_o);
        sdo(1'b1, IDX_SPEED, 8'h00, 32'h3, ABORT_RO);
        sdo(1'b1, IDX_SAVE, 8'h00, 32'h12345678, ABORT_OK);
        for (i = 0; i < 4; i++) begin
            settle();
            chk("store_req", 32'h0, store_req_o);
        end
        for (k = 0; k < 2; k++) begin
            slow <= k[0];
            sdo(1'b1, IDX_SAVE, 8'h00, 32'h55aaaa55, ABORT_OK);
            for (i = 0; i < 3 && store_req_o !== 1'b1; i++)
                settle();
            chk("store_req", 32'h1, store_req_o);
            for (i = 0; i < 40 && reboot_o !== 1'b1; i++)
                settle();
            chk("reboot", 32'h1, reboot_o);
            settle();
            chk("reboot", 32'h0, reboot_o);
            @(posedge clk_i);
            nrst_i <= 1'b0;
            repeat (2) @(posedge clk_i);
            nrst_i <= 1'b1;
        end
        rd(IDX_SCRATCH, 8'h01, 32'h0);
        conclude();
    end
endmodule
